/* hdl/tlc_pkg.sv */
// Shared constants and carrier types of the top-level control register bank
package tlc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_DEVCTRL = 8'h00;
  localparam logic [7:0] OFS_STATA = 8'h03;
  localparam logic [7:0] OFS_ENA = 8'h04;
  localparam logic [7:0] OFS_STATB = 8'h05;
  localparam logic [7:0] OFS_ENB = 8'h06;
  localparam logic [7:0] OFS_PINCFG = 8'h09;
  localparam logic [7:0] OFS_NVMCTL = 8'h2B;
  localparam logic [7:0] OFS_ADDRL = 8'h2C;
  localparam logic [7:0] OFS_ADDRH = 8'h2D;
  localparam logic [7:0] OFS_PROGDATA = 8'h2E;
  localparam logic [7:0] OFS_PKG = 8'h34;
  localparam logic [7:0] OFS_CRCCTL = 8'h36;
  localparam logic [7:0] OFS_CRCL = 8'h37;
  localparam logic [7:0] OFS_CRCH = 8'h38;
  localparam logic [7:0] OFS_SEC = 8'h39;

  // ==========================================================
  // Field positions and widths
  localparam int DEVEN_BIT = 1;
  localparam int CHG_BIT = 0;
  localparam int NC_COPYIN_BIT = 7;
  localparam int NC_COPYOUT_BIT = 6;
  localparam int CRCEN_BIT = 0;
  localparam int SEC_GLOBAL_BIT = 4;
  localparam int SEC_W = 5;
  localparam int IRQA_W = 5;
  localparam int IRQB_W = 8;
  localparam int IRQB_ADC_BIT = 1;
  localparam int IRQA_WDOG_BIT = 0;
  localparam int NVM_AW = 14;
  localparam int TIMER_W = 12;

  // ==========================================================
  // Array map
  localparam logic [13:0] NVM_FIRST = 14'h0000;
  localparam logic [13:0] NVM_CRC_LAST = 14'h3FBF;
  localparam logic [13:0] NVM_PROT_LO = 14'h3FC0;
  localparam logic [13:0] NVM_TOP = 14'h3FFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int NVM_PROG_TIME_NS = 10000;
  localparam int NVM_PROG_CYC = (NVM_PROG_TIME_NS * 1000) / CLK_PERIOD_PS;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlc_bus_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [13:0] addr;
    logic [7:0] wdata;
  } tlc_arr_req_s;

  typedef struct packed {
    logic we;
    logic re;
    logic [13:0] addr;
    logic [7:0] wdata;
  } tlc_ram_req_s;

  typedef enum logic [2:0] {
    ST_SECRD = 3'h0,
    ST_IDLE = 3'h1,
    ST_ARD = 3'h3,
    ST_AWR = 3'h2,
    ST_RRD = 3'h6,
    ST_RWT = 3'h7
  } tlc_state_e;

  typedef enum logic [2:0] {
    OP_SEC = 3'h0,
    OP_COPYIN = 3'h1,
    OP_COPYOUT = 3'h2,
    OP_BYTE = 3'h3,
    OP_CRC = 3'h4
  } tlc_op_e;

endpackage : tlc_pkg

/* hdl/tlc_crc16_step.sv */
// One-byte step of the 16-bit checksum, MSB first
`timescale 1ns/1ps
`default_nettype none
module tlc_crc16_step #(
  parameter logic [15:0] POLY = 16'h1021
) (
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [15:0] crcOut
);
  always_comb begin
    logic [15:0] c;
    c = crcIn ^ {dataIn, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ({c[14:0], 1'b0} ^ POLY) : {c[14:0], 1'b0};
    end
    crcOut = c;
  end
endmodule : tlc_crc16_step
`default_nettype wire

/* hdl/tlc_top_regs.sv */
// Top-level control register bank: interrupts, array controller, security
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Overview of operation
// - Channel copy and watchdog events set status A.
// - Status bits clear on write one; reset zero.
// - Status B bits map eight peripheral sources.
// - Converter completion sets status B bit one.
// - Enable bits match status positions.
// - Pin config bit zero enables charge detection.
// - Array to shadow copy holds core reset.
// - Shadow to array copy, bit clears at end.
// - Byte program done flag, cleared on read.
// - Byte program timeout sets failure flag.
// - Address from low and upper address registers.
// - Data register write starts byte programming.
// - Byte program refused in protected top range.
// - Checksum over array excluding top bytes.
// - Package register reports option in bits 7..6.
// - Global bit forces every sector debug off.
// - Sector bits raise sectors to read blocked.
// - Levels gate debugger reads or whole debugger.
// - Security loaded from top byte after reset.
// - Top byte written only by full copy.
// - Security level never goes back down.
// - Writes other than device control need device write enable bit set.
module tlc_top_regs #(
  parameter int unsigned PROG_CYC = tlc_pkg::NVM_PROG_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire tlc_pkg::tlc_bus_s bus,
  output logic [7:0] busRdata,
  input wire logic [tlc_pkg::IRQA_W-1:0] dmaWdogEvt,
  input wire logic [tlc_pkg::IRQB_W-1:0] periphEvt,
  output logic periphIrq,
  output logic chargeDetectEn,
  input wire logic [1:0] pkgStrap,
  output var tlc_pkg::tlc_arr_req_s arrReq,
  input wire logic arrAck,
  input wire logic arrFail,
  input wire logic [7:0] arrRdata,
  output var tlc_pkg::tlc_ram_req_s ramReq,
  input wire logic [7:0] ramRdata,
  output logic coreReset,
  input wire logic [13:0] dbgRdAddr,
  output logic dbgDisable,
  output logic dbgRdDeny,
  output logic [3:0] sectorRdBlock
);
  import tlc_pkg::*;

  typedef struct packed {
    tlc_state_e st;
    tlc_op_e op;
    logic [NVM_AW-1:0] addr;
    logic [7:0] data;
    logic [TIMER_W-1:0] timer;
    logic devEn;
    logic [IRQA_W-1:0] statA;
    logic [IRQA_W-1:0] enA;
    logic [IRQB_W-1:0] statB;
    logic [IRQB_W-1:0] enB;
    logic chg;
    logic copyOut;
    logic done;
    logic fail;
    logic [7:0] addrL;
    logic [7:0] addrH;
    logic [7:0] progData;
    logic crcEn;
    logic [15:0] crc;
    logic [1:0] pkg;
    logic pkgCaught;
    logic [SEC_W-1:0] sec;
    logic [7:0] rdata;
    logic irq;
    logic coreRst;
    tlc_arr_req_s arr;
    tlc_ram_req_s ram;
    logic dbgOff;
    logic dbgDeny;
    logic [3:0] rdBlock;
  } tlc_state_s;

  localparam logic [TIMER_W-1:0] TIMEOUT = TIMER_W'(PROG_CYC - 1);

  tlc_state_s r_reg;
  tlc_state_s r_next;
  logic [15:0] crcNext;
  logic wen;
  logic [NVM_AW-1:0] progAddr;

  // ==========================================================
  // Checksum datapath
  tlc_crc16_step #(.POLY(CRC_POLY)) u_crc (
    .crcIn(r_reg.crc),
    .dataIn(arrRdata),
    .crcOut(crcNext)
  );

  assign progAddr = {r_reg.addrH[5:0], r_reg.addrL};

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.rdata = 8'h00;
    r_next.ram.we = 1'b0;
    r_next.ram.re = 1'b0;
    // Device control stays writable, else the enable could never be set
    wen = bus.wr && (r_reg.devEn || bus.addr == OFS_DEVCTRL);

    // Clear first, then events, so a coincident event survives
    r_next.statA = r_reg.statA & ~((wen && bus.addr == OFS_STATA) ? bus.wdata[IRQA_W-1:0] : '0);
    r_next.statA = r_next.statA | dmaWdogEvt;
    r_next.statB = r_reg.statB & ~((wen && bus.addr == OFS_STATB) ? bus.wdata : '0);
    r_next.statB = r_next.statB | periphEvt;
    r_next.irq = (|(r_reg.statA & r_reg.enA)) || (|(r_reg.statB & r_reg.enB));

    if (wen) begin
      case (bus.addr)
        OFS_DEVCTRL: r_next.devEn = bus.wdata[DEVEN_BIT];
        OFS_ENA: r_next.enA = bus.wdata[IRQA_W-1:0];
        OFS_ENB: r_next.enB = bus.wdata;
        OFS_PINCFG: r_next.chg = bus.wdata[CHG_BIT];
        OFS_ADDRL: r_next.addrL = bus.wdata;
        OFS_ADDRH: r_next.addrH = bus.wdata;
        OFS_PROGDATA: r_next.progData = bus.wdata;
        OFS_CRCCTL: r_next.crcEn = bus.wdata[CRCEN_BIT];
        OFS_CRCL: r_next.crc[7:0] = bus.wdata;
        OFS_CRCH: r_next.crc[15:8] = bus.wdata;
        default: ;
      endcase
    end

    if (bus.rd) begin
      case (bus.addr)
        OFS_DEVCTRL: r_next.rdata = {6'h00, r_reg.devEn, 1'b0};
        OFS_STATA: r_next.rdata = {3'h0, r_reg.statA};
        OFS_ENA: r_next.rdata = {3'h0, r_reg.enA};
        OFS_STATB: r_next.rdata = r_reg.statB;
        OFS_ENB: r_next.rdata = r_reg.enB;
        OFS_PINCFG: r_next.rdata = {7'h00, r_reg.chg};
        OFS_NVMCTL: begin
          r_next.rdata = {1'b0, r_reg.copyOut, r_reg.done, r_reg.fail, 4'h0};
          r_next.done = 1'b0;
        end
        OFS_ADDRL: r_next.rdata = r_reg.addrL;
        OFS_ADDRH: r_next.rdata = r_reg.addrH;
        OFS_PROGDATA: r_next.rdata = r_reg.progData;
        OFS_PKG: r_next.rdata = {r_reg.pkg, 6'h00};
        OFS_CRCCTL: r_next.rdata = {7'h00, r_reg.crcEn};
        OFS_CRCL: r_next.rdata = r_reg.crc[7:0];
        OFS_CRCH: r_next.rdata = r_reg.crc[15:8];
        OFS_SEC: r_next.rdata = {3'h0, r_reg.sec};
        default: r_next.rdata = 8'h00;
      endcase
    end

    // Strap is sampled once, after reset release
    if (!r_reg.pkgCaught) begin
      r_next.pkg = pkgStrap;
      r_next.pkgCaught = 1'b1;
    end

    // Debugger gating
    r_next.dbgOff = r_reg.sec[SEC_GLOBAL_BIT];
    r_next.rdBlock = r_reg.sec[SEC_GLOBAL_BIT] ? 4'hF : r_reg.sec[3:0];
    r_next.dbgDeny = r_reg.sec[SEC_GLOBAL_BIT] ||
                     (dbgRdAddr <= NVM_CRC_LAST && r_reg.sec[dbgRdAddr[13:12]]);

    unique case (r_reg.st)
      ST_SECRD: begin
        r_next.op = OP_SEC;
        r_next.addr = NVM_TOP;
        r_next.timer = '0;
        r_next.st = ST_ARD;
      end
      ST_IDLE: begin
        r_next.timer = '0;
        if (wen && bus.addr == OFS_NVMCTL && bus.wdata[NC_COPYIN_BIT]) begin
          r_next.op = OP_COPYIN;
          r_next.addr = NVM_FIRST;
          r_next.coreRst = 1'b1;
          r_next.st = ST_ARD;
        end else if (wen && bus.addr == OFS_NVMCTL && bus.wdata[NC_COPYOUT_BIT]) begin
          r_next.op = OP_COPYOUT;
          r_next.addr = NVM_FIRST;
          r_next.copyOut = 1'b1;
          r_next.st = ST_RRD;
        end else if (wen && bus.addr == OFS_PROGDATA) begin
          r_next.fail = 1'b0;
          // Top byte only changes through the full copy
          if (progAddr >= NVM_PROT_LO) begin
            r_next.done = 1'b1;
            r_next.fail = 1'b1;
          end else begin
            r_next.op = OP_BYTE;
            r_next.addr = progAddr;
            r_next.data = bus.wdata;
            r_next.st = ST_AWR;
          end
        end else if (r_reg.crcEn) begin
          r_next.op = OP_CRC;
          r_next.crc = CRC_INIT;
          r_next.addr = NVM_FIRST;
          r_next.st = ST_ARD;
        end
      end
      ST_ARD: begin
        r_next.arr = '{req: 1'b1, we: 1'b0, addr: r_reg.addr, wdata: 8'h00};
        r_next.timer = r_reg.timer + 1'b1;
        if (r_reg.arr.req && arrAck) begin
          r_next.arr.req = 1'b0;
          r_next.timer = '0;
          r_next.addr = r_reg.addr + 1'b1;
          unique case (r_reg.op)
            OP_COPYIN: begin
              r_next.ram = '{we: 1'b1, re: 1'b0, addr: r_reg.addr, wdata: arrRdata};
              if (r_reg.addr == NVM_TOP) begin
                r_next.coreRst = 1'b0;
                r_next.st = ST_IDLE;
              end
            end
            OP_CRC: begin
              r_next.crc = crcNext;
              if (r_reg.addr == NVM_CRC_LAST) begin
                r_next.crcEn = 1'b0;
                r_next.st = ST_IDLE;
              end
            end
            default: begin
              r_next.sec = arrRdata[SEC_W-1:0];
              r_next.st = ST_IDLE;
            end
          endcase
        end else if (r_reg.timer == TIMEOUT) begin
          // An array that never answers must not hang the core in reset
          r_next.arr.req = 1'b0;
          r_next.fail = 1'b1;
          r_next.coreRst = 1'b0;
          r_next.crcEn = 1'b0;
          r_next.st = ST_IDLE;
        end
      end
      ST_RRD: begin
        r_next.ram = '{we: 1'b0, re: 1'b1, addr: r_reg.addr, wdata: 8'h00};
        r_next.st = ST_RWT;
      end
      ST_RWT: begin
        if (!r_reg.ram.re) begin
          r_next.data = ramRdata;
          if (r_reg.addr == NVM_TOP) begin
            r_next.data[SEC_W-1:0] = ramRdata[SEC_W-1:0] | r_reg.sec;
          end
          r_next.timer = '0;
          r_next.st = ST_AWR;
        end
      end
      ST_AWR: begin
        r_next.arr = '{req: 1'b1, we: 1'b1, addr: r_reg.addr, wdata: r_reg.data};
        r_next.timer = r_reg.timer + 1'b1;
        if (r_reg.arr.req && arrAck) begin
          r_next.arr.req = 1'b0;
          r_next.timer = '0;
          r_next.fail = r_reg.fail | arrFail;
          if (r_reg.op == OP_BYTE) begin
            r_next.done = 1'b1;
            r_next.st = ST_IDLE;
          end else if (r_reg.addr == NVM_TOP) begin
            r_next.copyOut = 1'b0;
            r_next.st = ST_IDLE;
          end else begin
            r_next.addr = r_reg.addr + 1'b1;
            r_next.st = ST_RRD;
          end
        end else if (r_reg.timer == TIMEOUT) begin
          r_next.arr.req = 1'b0;
          r_next.fail = 1'b1;
          r_next.done = (r_reg.op == OP_BYTE) ? 1'b1 : r_next.done;
          r_next.copyOut = 1'b0;
          r_next.st = ST_IDLE;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign busRdata = r_reg.rdata;
  assign periphIrq = r_reg.irq;
  assign chargeDetectEn = r_reg.chg;
  assign arrReq = r_reg.arr;
  assign ramReq = r_reg.ram;
  assign coreReset = r_reg.coreRst;
  assign dbgDisable = r_reg.dbgOff;
  assign dbgRdDeny = r_reg.dbgDeny;
  assign sectorRdBlock = r_reg.rdBlock;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_irq;
    1 |=> periphIrq == ((|($past(r_reg.statA) & $past(r_reg.enA))) || (|($past(r_reg.statB) & $past(r_reg.enB))));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output mismatch");

  property p_wdog;
    dmaWdogEvt[IRQA_WDOG_BIT] |=> r_reg.statA[IRQA_WDOG_BIT];
  endproperty
  a_wdog: assert property (p_wdog) else $error("event flag not set");

  property p_adc;
    periphEvt[IRQB_ADC_BIT] |=> ##1 r_reg.statB[IRQB_ADC_BIT] || ($past(wen) && $past(bus.addr) == OFS_STATB);
  endproperty
  a_adc: assert property (p_adc) else $error("converter flag lost");

  property p_w1c;
    (wen && bus.addr == OFS_STATB && periphEvt == '0) |=> ((r_reg.statB & $past(bus.wdata)) == '0);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_locked;
    (bus.wr && !r_reg.devEn && bus.addr == OFS_ENB) |=> $stable(r_reg.enB);
  endproperty
  a_locked: assert property (p_locked) else $error("write taken while locked");

  property p_prot;
    (wen && bus.addr == OFS_PROGDATA && r_reg.st == ST_IDLE && progAddr >= NVM_PROT_LO)
      |=> (r_reg.fail && r_reg.done && r_reg.st == ST_IDLE);
  endproperty
  a_prot: assert property (p_prot) else $error("protected byte programmed");

  property p_hold;
    (r_reg.op == OP_COPYIN && r_reg.st != ST_IDLE) |-> coreReset;
  endproperty
  a_hold: assert property (p_hold) else $error("core not held during copy");

  property p_fwd;
    (arrReq.req && arrReq.we && arrReq.addr == NVM_TOP) |-> ((arrReq.wdata[SEC_W-1:0] & r_reg.sec) == r_reg.sec);
  endproperty
  a_fwd: assert property (p_fwd) else $error("security level lowered");

  property p_global;
    r_reg.sec[SEC_GLOBAL_BIT] |=> (dbgDisable && dbgRdDeny && sectorRdBlock == 4'hF);
  endproperty
  a_global: assert property (p_global) else $error("global level not applied");

  property p_tmo;
    (r_reg.st == ST_AWR && r_reg.op == OP_BYTE && r_reg.timer == TIMEOUT && !(r_reg.arr.req && arrAck))
      |=> (r_reg.fail && r_reg.done);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not flagged");

  c_byte: cover property (r_reg.st == ST_AWR && r_reg.op == OP_BYTE ##[1:20] r_reg.done);
  c_copyin: cover property (r_reg.op == OP_COPYIN && $fell(coreReset));
  c_crc: cover property (r_reg.op == OP_CRC && $fell(r_reg.crcEn));
  c_irq: cover property ($rose(periphIrq));

endmodule : tlc_top_regs
`default_nettype wire

/* tb/top_level_control_regs_test.sv */
// Self-checking bench of the top-level control register bank
`timescale 1ns/1ps
`default_nettype none
module top_level_control_regs_test;
  import tlc_pkg::*;
  localparam int PCYC = 8;
  localparam int LIMIT = 99000;
  logic mclk;
  logic nrst;
  tlc_bus_s bus;
  logic [7:0] busRdata;
  logic [4:0] dmaWdogEvt;
  logic [7:0] periphEvt;
  logic periphIrq;
  logic chargeDetectEn;
  logic [1:0] pkgStrap;
  tlc_arr_req_s arrReq;
  logic arrAck;
  logic arrFail;
  logic [7:0] arrRdata;
  tlc_ram_req_s ramReq;
  logic [7:0] ramRdata;
  logic coreReset;
  logic [13:0] dbgRdAddr;
  logic dbgDisable;
  logic dbgRdDeny;
  logic [3:0] sectorRdBlock;
  int seed = 32'h9f00;
  int failCount = 0;
  int checkCount = 0;
  int cycles = 0;
  bit mute = 1'b0;
  bit failInj = 1'b0;
  logic [7:0] secVal = 8'h05;
  logic [7:0] stA, stB, enA, enB, r;
  logic [31:0] v;
  logic [21:0] wrQ[$];
  logic [21:0] ramQ[$];
  logic [7:0] ofs [16] = '{OFS_DEVCTRL, OFS_STATA, OFS_ENA, OFS_STATB, OFS_ENB, OFS_PINCFG, OFS_NVMCTL,
    OFS_ADDRL, OFS_ADDRH, OFS_PROGDATA, OFS_CRCCTL, OFS_CRCL, OFS_CRCH, OFS_PKG, OFS_SEC, 8'h7F};

  tlc_top_regs #(.PROG_CYC(PCYC)) dut (.mclk(mclk), .nrst(nrst), .bus(bus), .busRdata(busRdata),
    .dmaWdogEvt(dmaWdogEvt), .periphEvt(periphEvt), .periphIrq(periphIrq), .chargeDetectEn(chargeDetectEn),
    .pkgStrap(pkgStrap), .arrReq(arrReq), .arrAck(arrAck), .arrFail(arrFail), .arrRdata(arrRdata),
    .ramReq(ramReq), .ramRdata(ramRdata), .coreReset(coreReset), .dbgRdAddr(dbgRdAddr),
    .dbgDisable(dbgDisable), .dbgRdDeny(dbgRdDeny), .sectorRdBlock(sectorRdBlock));

  // ==========================================================
  // Clock, array responder, watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [7:0] memVal(input logic [13:0] a);
    memVal = (a == NVM_TOP) ? secVal : (a[7:0] ^ {2'h0, a[13:8]});
  endfunction : memVal

  // Idle array data toggles so stale bytes never look valid
  always @(posedge mclk) begin
    // Factory bytes stay as the array holds them
    ramRdata <= (ramReq.addr inside {[14'h3FF8:14'h3FFA]}) ? memVal(ramReq.addr) : 8'($random(seed));
    if (ramReq.we) begin
      ramQ.push_back({ramReq.addr, ramReq.wdata});
    end
    arrFail <= failInj;
    if (arrReq.req && !arrAck && !mute) begin
      arrAck <= 1'b1;
      arrRdata <= memVal(arrReq.addr);
      if (arrReq.we) begin
        wrQ.push_back({arrReq.addr, arrReq.wdata});
      end
    end else begin
      arrAck <= 1'b0;
      arrRdata <= ~arrRdata;
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failCount++;
      wrapUp();
    end
  end

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    d = busRdata;
  endtask : rd

  task automatic doReset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (20) @(posedge mclk);
  endtask : doReset

  task automatic dbgChk();
    logic [13:0] a;
    for (int i = 0; i < 18; i++) begin
      a = (i == 0) ? 14'h3FBF : (i == 1) ? 14'h3FC0 : 14'($random(seed));
      @(posedge mclk);
      dbgRdAddr <= a;
      repeat (2) @(posedge mclk);
      #1;
      chk(8'(dbgRdDeny), 8'(secVal[4] || (a <= NVM_CRC_LAST && secVal[a[13:12]])));
    end
    chk(8'(dbgDisable), 8'(secVal[4]));
    chk(8'(sectorRdBlock), secVal[4] ? 8'h0F : {4'h0, secVal[3:0]});
  endtask : dbgChk

  task automatic progChk(input logic [13:0] a, input logic [7:0] e, input bit w);
    logic [7:0] d, s;
    logic [21:0] q;
    d = 8'($random(seed));
    // Reserved upper bits set on purpose; they must not reach the address
    wr(OFS_ADDRL, a[7:0]);
    wr(OFS_ADDRH, {2'b11, a[13:8]});
    wr(OFS_PROGDATA, d);
    s = 8'h00;
    for (int i = 0; i < 40 && !s[5]; i++) rd(OFS_NVMCTL, s);
    chk(s, e);
    chk(8'(wrQ.size()), 8'(w));
    if (w && wrQ.size() > 0) begin
      q = wrQ.pop_front();
      chk(q[7:0], d);
      chk({q[15:8]}, a[7:0]);
      chk({2'h0, q[21:16]}, {2'h0, a[13:8]});
    end
    rd(OFS_NVMCTL, s);
    chk(s, e & 8'h10);
  endtask : progChk

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrapUp

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] c;
    nrst = 1'b0;
    bus = '0;
    dmaWdogEvt = 5'h00;
    periphEvt = 8'h00;
    pkgStrap = 2'b10;
    arrAck = 1'b0;
    arrFail = 1'b0;
    arrRdata = 8'h00;
    ramRdata = 8'h00;
    dbgRdAddr = 14'h0000;
    doReset();
    foreach (ofs[i]) begin
      rd(ofs[i], r);
      chk(r, (ofs[i] == OFS_PKG) ? 8'h80 : (ofs[i] == OFS_SEC) ? secVal : 8'h00);
    end
    dbgChk();
    wr(OFS_ENA, 8'h1F);
    rd(OFS_ENA, r);
    chk(r, 8'h00);
    wr(OFS_ENB, 8'hFF);
    rd(OFS_ENB, r);
    chk(r, 8'h00);
    wr(OFS_DEVCTRL, 8'h02);
    wr(OFS_PINCFG, 8'hFF);
    rd(OFS_PINCFG, r);
    chk(r, 8'h01);
    chk(8'(chargeDetectEn), 8'h01);
    stA = 8'h00;
    stB = 8'h00;
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      @(posedge mclk);
      dmaWdogEvt <= v[4:0];
      periphEvt <= v[15:8];
      @(posedge mclk);
      dmaWdogEvt <= 5'h00;
      periphEvt <= 8'h00;
      stA = stA | {3'h0, v[4:0]};
      stB = stB | v[15:8];
      v = $random(seed);
      wr(OFS_ENA, v[7:0]);
      enA = {3'h0, v[4:0]};
      wr(OFS_ENB, v[15:8]);
      enB = v[15:8];
      rd(OFS_STATA, r);
      chk(r, stA);
      rd(OFS_STATB, r);
      chk(r, stB);
      rd(OFS_ENA, r);
      chk(r, enA);
      chk(8'(periphIrq), 8'(|((stA & enA) | (stB & enB))));
      v = $random(seed);
      wr(OFS_STATA, v[7:0]);
      stA = stA & ~v[7:0] & 8'h1F;
      wr(OFS_STATB, v[15:8]);
      stB = stB & ~v[15:8];
      rd(OFS_STATB, r);
      chk(r, stB);
    end
    progChk(14'h0123, 8'h20, 1'b1);
    progChk(14'h3FBF, 8'h20, 1'b1);
    progChk(14'h3FC0, 8'h30, 1'b0);
    progChk(14'h3FFE, 8'h30, 1'b0);
    progChk(14'h3FFF, 8'h30, 1'b0);
    failInj = 1'b1;
    progChk(14'h0200, 8'h30, 1'b1);
    failInj = 1'b0;
    mute = 1'b1;
    progChk(14'h0201, 8'h30, 1'b0);
    mute = 1'b0;
    progChk(14'h0202, 8'h20, 1'b1);
    // Array to shadow copy, cut short by an array that stops answering
    wr(OFS_NVMCTL, 8'h80);
    repeat (10) @(posedge mclk);
    rd(OFS_NVMCTL, r);
    chk(r, 8'h00);
    chk(8'(coreReset), 8'h01);
    mute = 1'b1;
    repeat (16) @(posedge mclk);
    #1;
    chk(8'(coreReset), 8'h00);
    chk(8'(ramQ.size() >= 2), 8'h01);
    for (int i = 0; i < 2; i++) begin
      chk(ramQ[i][7:0], memVal(14'(i)));
      chk(ramQ[i][15:8], 8'(i));
    end
    // Shadow to array copy, cut short the same way
    wr(OFS_NVMCTL, 8'h40);
    rd(OFS_NVMCTL, r);
    chk(r, 8'h50);
    repeat (20) @(posedge mclk);
    rd(OFS_NVMCTL, r);
    chk(r, 8'h10);
    mute = 1'b0;
    // Reference checksum over everything below the top 64 bytes
    c = CRC_INIT;
    for (int a = 0; a <= int'(NVM_CRC_LAST); a++) begin
      c = c ^ {memVal(14'(a)), 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    wr(OFS_CRCCTL, 8'h01);
    r = 8'h01;
    for (int i = 0; i < 45000 && r[0]; i++) rd(OFS_CRCCTL, r);
    rd(OFS_CRCL, r);
    chk(r, c[7:0]);
    rd(OFS_CRCH, r);
    chk(r, c[15:8]);
    secVal = 8'h1A;
    pkgStrap <= 2'b11;
    doReset();
    rd(OFS_SEC, r);
    chk(r, 8'h1A);
    rd(OFS_PKG, r);
    chk(r, 8'hC0);
    rd(OFS_STATB, r);
    chk(r, 8'h00);
    dbgChk();
    wrapUp();
  end
endmodule : top_level_control_regs_test
`default_nettype wire
